// >>> design/diag_adc_alarm_monitor.sv
// diagnostic converter control, result registers and alarm response
// Contract
// - slots one, two convert sense pins 0, 1
// - external results stored as unsigned straight binary
// - codes span 000 through 800 to FFF
// - rate field picks 640/1280/2560/3840 Hz
// - span bit chooses span only with high supply
// - sense results written to 24h and 25h
// - slot three temperature at 2560 Hz, 26h
// - self-diagnostic results reported at 27h
// - slots four to seven fixed rate, reference span
// - output monitor span doubles on high supply
// - offset bypass substitutes 2Eh for offset
// - data bypass replaces conversion with 2Eh value
// - out-of-window result sets its status bit
// - status latched, read clears, persisting sets again
// - unmasked events drive alarm pin, masked don't
// - fault clearing reloads dac from active registers
// - only listed faults steer dac response
// - action codes 0-3; code 1 forces clear
// - code 2 level from polarity or pin
// - special config reset only at power-on
// - code 3 hi-z; highest active code wins
// - stored offset subtracted unless offset bypass
`timescale 1ns/1ps
`default_nettype none
module diag_adc_alarm_monitor #(
  parameter int unsigned PER_640_CYC  = diag_adc_pkg::CLK_HZ / diag_adc_pkg::RATE_640_HZ,
  parameter int unsigned PER_1280_CYC = diag_adc_pkg::CLK_HZ / diag_adc_pkg::RATE_1280_HZ,
  parameter int unsigned PER_2560_CYC = diag_adc_pkg::CLK_HZ / diag_adc_pkg::RATE_2560_HZ,
  parameter int unsigned PER_3840_CYC = diag_adc_pkg::CLK_HZ / diag_adc_pkg::RATE_3840_HZ
) (
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  input  wire logic        POR_I,
  input  wire logic [7:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output var  logic [31:0] AVS_READDATA_O,
  output var  logic        AVS_WAITREQUEST_O,
  output var  logic [1:0]  AVS_RESPONSE_O,
  input  wire logic        EXT_SENSE_IN1_I,
  input  wire logic        HIGH_SUPPLY_I,
  output var  logic        ADC_START_O,
  output var  logic [3:0]  ADC_SLOT_O,
  output var  logic        ADC_SPAN_DOUBLE_O,
  input  wire logic        ADC_DONE_I,
  input  wire logic [11:0] ADC_DATA_I,
  input  wire logic        CRC_FAULT_I,
  input  wire logic        WATCHDOG_FAULT_I,
  input  wire logic        REF_FAULT_I,
  input  wire logic        OVERHEAT_FAULT_I,
  input  wire logic        UNDERTEMP_FAULT_I,
  input  wire logic        MISC_EVENT_I,
  output var  logic        ALARM_O,
  output var  logic [1:0]  DAC_RESP_O,
  output var  logic        DAC_ALARM_HIGH_O,
  output var  logic        DAC_RELOAD_O
);
  import diag_adc_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_CONV = 3'b100
  } seq_e;

  logic              rst_any;
  logic [1:0]        s1_sync_q;
  logic [1:0]        hs_sync_q;
  logic [3:0]        ctrl_q;
  logic [13:0]       byp_q;
  logic [15:0]       thr_q [0:2];
  logic [23:0]       sd4_thr_q;
  logic [13:0]       mask_q;
  logic [25:0]       act_q;
  logic [1:0]        spec_q;
  logic [11:0]       offset_q;
  logic [11:0]       res_q [0:3];
  logic              ack_q;
  logic [31:0]       rdata_q;
  logic [1:0]        resp_q;
  logic [31:0]       rd_val;
  logic [31:0]       wmerge;
  logic              hit;
  logic [5:0]        idx;
  logic              wr_en;
  logic [13:0]       clr_vec;
  logic [13:0]       stat;
  logic [13:0]       set_vec;
  seq_e              st_q;
  logic [3:0]        slot_q;
  logic [15:0]       timer_q;
  logic [15:0]       period;
  logic              expire;
  logic              sub_en;
  logic              commit;
  logic [11:0]       value;
  logic [11:0]       lo;
  logic [11:0]       hi;
  logic              outside;
  logic [7:0]        cond_q;
  logic [7:0]        evt_vec;
  logic [12:0]       cond_all;
  logic [1:0]        resp_d;
  logic              span_d;
  logic              start_q;
  logic              span_q;

  assign rst_any = RST_I | POR_I;
  assign sub_en  = byp_q[BYP_RES_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; only the second stage is read
  always_ff @(posedge CLK_I) begin
    s1_sync_q <= {s1_sync_q[0], EXT_SENSE_IN1_I};
    hs_sync_q <= {hs_sync_q[0], HIGH_SUPPLY_I};
  end

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait state, data and answer registered
  assign idx               = AVS_ADDRESS_I[7:2];
  assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~ack_q;
  assign AVS_READDATA_O    = rdata_q;
  assign AVS_RESPONSE_O    = resp_q;
  assign wr_en             = AVS_WRITE_I & ack_q & hit;

  always_comb begin
    hit    = 1'b1;
    rd_val = 32'(0);
    case (idx)
      IDX_CTRL:    rd_val = 32'(ctrl_q);
      IDX_EXT0:    rd_val = 32'(res_q[0]);
      IDX_EXT1:    rd_val = 32'(res_q[1]);
      IDX_TEMP:    rd_val = 32'(res_q[2]);
      IDX_DIAG:    rd_val = 32'(res_q[3]);
      IDX_OFFSET:  rd_val = 32'(offset_q);
      IDX_BYP:     rd_val = 32'(byp_q);
      IDX_THR0:    rd_val = 32'(thr_q[0]);
      IDX_THR1:    rd_val = 32'(thr_q[1]);
      IDX_THRT:    rd_val = 32'(thr_q[2]);
      IDX_SD4_THR: rd_val = 32'(sd4_thr_q);
      IDX_STATUS:  rd_val = 32'(stat);
      IDX_MASK:    rd_val = 32'(mask_q);
      IDX_ACT:     rd_val = 32'(act_q);
      IDX_SPECIAL: rd_val = 32'(spec_q);
      default:     hit = 1'b0;
    endcase
    for (int b = 0; b < 4; b++) begin
      wmerge[8*b +: 8] = AVS_BYTEENABLE_I[b] ? AVS_WRITEDATA_I[8*b +: 8] : rd_val[8*b +: 8];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (rst_any) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
      resp_q  <= RESP_OK;
    end else begin
      ack_q <= (AVS_READ_I | AVS_WRITE_I) & ~ack_q;
      if ((AVS_READ_I | AVS_WRITE_I) & ~ack_q) begin
        rdata_q <= AVS_READ_I ? rd_val : 32'h0000_0000;
        resp_q  <= hit ? RESP_OK : RESP_ERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software-written configuration
  always_ff @(posedge CLK_I) begin
    if (rst_any) begin
      ctrl_q    <= '0;
      byp_q     <= '0;
      thr_q[0]  <= THR_RST;
      thr_q[1]  <= THR_RST;
      thr_q[2]  <= THR_RST;
      sd4_thr_q <= SD4_THR_RST;
      mask_q    <= MASK_RST;
      act_q     <= '0;
    end else if (wr_en) begin
      case (idx)
        IDX_CTRL:    ctrl_q    <= wmerge[3:0];
        IDX_BYP:     byp_q     <= wmerge[13:0];
        IDX_THR0:    thr_q[0]  <= wmerge[15:0];
        IDX_THR1:    thr_q[1]  <= wmerge[15:0];
        IDX_THRT:    thr_q[2]  <= wmerge[15:0];
        IDX_SD4_THR: sd4_thr_q <= wmerge[23:0];
        IDX_MASK:    mask_q    <= wmerge[13:0];
        IDX_ACT:     act_q     <= wmerge[25:0];
        default:     ;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (POR_I) begin
      spec_q <= '0;
    end else if (wr_en && idx == IDX_SPECIAL) begin
      spec_q <= wmerge[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // slot sequencer: offset, two sense pins, temperature, five diagnostics
  // rate per slot
  always_comb begin
    period = 16'(PER_2560_CYC - 1);
    if (slot_q == SLOT_EXT0 || slot_q == SLOT_EXT1) begin
      case (ctrl_q[CTRL_RATE_LSB +: 2])
        2'd0:    period = 16'(PER_640_CYC - 1);
        2'd1:    period = 16'(PER_1280_CYC - 1);
        2'd2:    period = 16'(PER_2560_CYC - 1);
        default: period = 16'(PER_3840_CYC - 1);
      endcase
    end
  end

  assign expire = (st_q == ST_WAIT) && (timer_q == period);
  assign commit = ((st_q == ST_CONV) && ADC_DONE_I) || (expire && sub_en);

  // span doubles only with high supply
  always_comb begin
    if (slot_q == SLOT_EXT0 || slot_q == SLOT_EXT1) begin
      span_d = hs_sync_q[1] & ~ctrl_q[CTRL_SPAN_BIT];
    end else if (slot_q == SLOT_SD4) begin
      span_d = hs_sync_q[1];
    end else begin
      span_d = 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (rst_any) begin
      st_q    <= ST_IDLE;
      slot_q  <= SLOT_OFFSET;
      timer_q <= '0;
      start_q <= 1'b0;
      span_q  <= 1'b0;
    end else begin
      start_q <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          timer_q <= '0;
          slot_q  <= SLOT_OFFSET;
          if (ctrl_q[CTRL_RUN_BIT]) begin
            st_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (!ctrl_q[CTRL_RUN_BIT]) begin
            st_q <= ST_IDLE;
          end else if (expire) begin
            timer_q <= '0;
            if (sub_en) begin
              slot_q <= (slot_q == SLOT_SD4) ? SLOT_OFFSET : slot_q + 4'd1;
            end else begin
              start_q <= 1'b1;
              span_q  <= span_d;
              st_q    <= ST_CONV;
            end
          end else begin
            timer_q <= timer_q + 16'd1;
          end
        end
        ST_CONV: begin
          // a started conversion always finishes before stopping
          if (ADC_DONE_I) begin
            slot_q <= (slot_q == SLOT_SD4) ? SLOT_OFFSET : slot_q + 4'd1;
            st_q   <= ctrl_q[CTRL_RUN_BIT] ? ST_WAIT : ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // slot number drives the converter input select
  assign ADC_SLOT_O        = slot_q;
  assign ADC_START_O       = start_q;
  assign ADC_SPAN_DOUBLE_O = span_q;

  ////////////////////////////////////////////////////////////////////////////
  // result correction and storage
  // offset substitution or subtraction
  result_path u_path (
    .conv_i          (ADC_DATA_I),
    .subst_i         (byp_q[11:0]),
    .offset_i        (offset_q),
    .offset_sub_en_i (byp_q[BYP_OFS_BIT]),
    .result_sub_en_i (sub_en),
    .offset_slot_i   (slot_q == SLOT_OFFSET),
    .value_o         (value)
  );

  always_ff @(posedge CLK_I) begin
    if (rst_any) begin
      offset_q <= '0;
      for (int i = 0; i < 4; i++) begin
        res_q[i] <= '0;
      end
    end else if (commit) begin
      case (slot_q)
        SLOT_OFFSET: offset_q <= value;
        SLOT_EXT0:   res_q[0] <= value;
        SLOT_EXT1:   res_q[1] <= value;
        SLOT_TEMP:   res_q[2] <= value;
        default:     res_q[3] <= value;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // window check, status and response
  always_comb begin
    lo = CODE_MIN;
    hi = CODE_MAX;
    case (slot_q)
      SLOT_EXT0: begin
        lo = {thr_q[0][7:0], THR_LO_LSB};
        hi = {thr_q[0][15:8], THR_HI_LSB};
      end
      SLOT_EXT1: begin
        lo = {thr_q[1][7:0], THR_LO_LSB};
        hi = {thr_q[1][15:8], THR_HI_LSB};
      end
      SLOT_TEMP: begin
        lo = {thr_q[2][7:0], THR_LO_LSB};
        hi = {thr_q[2][15:8], THR_HI_LSB};
      end
      SLOT_SD4: begin
        lo = sd4_thr_q[11:0];
        hi = sd4_thr_q[23:12];
      end
      default: begin
        if (slot_q >= SLOT_SD0) begin
          lo = SD_LO_TAB[12*(slot_q - SLOT_SD0) +: 12];
          hi = SD_HI_TAB[12*(slot_q - SLOT_SD0) +: 12];
        end
      end
    endcase
    outside = (value < lo) || (value > hi);
    evt_vec = '0;
    if (commit && slot_q != SLOT_OFFSET && outside) begin
      evt_vec = 8'(8'd1 << (slot_q - 4'd1));
    end
  end

  always_ff @(posedge CLK_I) begin
    if (rst_any) begin
      cond_q <= '0;
    end else if (commit && slot_q != SLOT_OFFSET) begin
      cond_q[3'(slot_q - 4'd1)] <= outside;
    end
  end

  assign set_vec = {MISC_EVENT_I, UNDERTEMP_FAULT_I, OVERHEAT_FAULT_I, REF_FAULT_I,
                    WATCHDOG_FAULT_I, CRC_FAULT_I, evt_vec};
  // clear only the bits that the read returned
  assign clr_vec = (AVS_READ_I && ack_q && idx == IDX_STATUS) ? rdata_q[13:0] : '0;

  for (genvar g = 0; g < NSRC; g++) begin : g_flag
    fault_flag u_flag (
      .clk_i  (CLK_I),
      .rst_i  (rst_any),
      .set_i  (set_vec[g]),
      .clr_i  (clr_vec[g]),
      .flag_o (stat[g])
    );
  end

  // the last status source only reaches the pin
  assign cond_all = {UNDERTEMP_FAULT_I, OVERHEAT_FAULT_I, REF_FAULT_I,
                     WATCHDOG_FAULT_I, CRC_FAULT_I, cond_q};

  always_comb begin
    resp_d = ACT_NONE;
    for (int i = 0; i < NRESP; i++) begin
      if (cond_all[i] && act_q[2*i +: 2] > resp_d) begin
        resp_d = act_q[2*i +: 2];
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (rst_any) begin
      DAC_RESP_O       <= ACT_NONE;
      DAC_RELOAD_O     <= 1'b0;
      DAC_ALARM_HIGH_O <= 1'b0;
      ALARM_O          <= 1'b0;
    end else begin
      DAC_RESP_O       <= resp_d;
      // reload active code when the response ends
      DAC_RELOAD_O     <= (DAC_RESP_O != ACT_NONE) && (resp_d == ACT_NONE);
      // polarity bit or enabled sense pin
      DAC_ALARM_HIGH_O <= spec_q[SPC_POL_BIT] | (~spec_q[SPC_DIS_BIT] & s1_sync_q[1]);
      // masked events stay off the pin
      ALARM_O          <= |(stat & ~mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (rst_any);

  sequence s_issue_ext;
    expire && !sub_en && (slot_q == SLOT_EXT0 || slot_q == SLOT_EXT1);
  endsequence

  a_ext_span: assert property (s_issue_ext |=> ADC_START_O &&
    ADC_SPAN_DOUBLE_O == $past(hs_sync_q[1] & ~ctrl_q[CTRL_SPAN_BIT]))
    else $error("sense span not chosen by span bit and supply");

  a_out_span: assert property (expire && !sub_en && slot_q == SLOT_SD4
    |=> ADC_SPAN_DOUBLE_O == $past(hs_sync_q[1]))
    else $error("output monitor span not following supply");

  a_fixed_span: assert property (ADC_START_O && ADC_SLOT_O >= SLOT_TEMP
    && ADC_SLOT_O < SLOT_SD4 |-> !ADC_SPAN_DOUBLE_O)
    else $error("fixed channel used doubled span");

  a_ext0_store: assert property (commit && slot_q == SLOT_EXT0
    |=> res_q[0] == $past(value))
    else $error("sense 0 result not stored");

  a_bypass_skip: assert property (expire && sub_en |=> !ADC_START_O
    && st_q == ST_WAIT)
    else $error("conversion started during data bypass");

  a_status_hold: assert property (stat[0] && !clr_vec[0] |=> stat[0])
    else $error("status bit lost without a read");

  a_set_wins: assert property (set_vec[2] |=> stat[2])
    else $error("event did not set status");

  a_pin_mask: assert property ((stat & ~mask_q) == '0 ##1
    (stat & ~mask_q) == '0 |-> !ALARM_O)
    else $error("alarm pin raised by masked events");

  sequence s_resp_end;
    DAC_RESP_O != ACT_NONE ##1 DAC_RESP_O == ACT_NONE;
  endsequence

  a_reload_end: assert property (s_resp_end |-> DAC_RELOAD_O)
    else $error("no reload when response ended");

  a_hiz_wins: assert property (cond_all[9] && act_q[19:18] == ACT_HIZ
    |=> DAC_RESP_O == ACT_HIZ)
    else $error("hi-z response did not take precedence");

endmodule
`default_nettype wire

// >>> design/diag_adc_pkg.sv
// constants shared by the diagnostic converter control and alarm logic
package diag_adc_pkg;

  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned RATE_640_HZ  = 640;
  localparam int unsigned RATE_1280_HZ = 1280;
  localparam int unsigned RATE_2560_HZ = 2560;
  localparam int unsigned RATE_3840_HZ = 3840;

  localparam int unsigned DATA_W = 12;
  localparam int unsigned NSRC   = 14;
  localparam int unsigned NRESP  = 13;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_CTRL    = 6'h20;
  localparam logic [5:0] IDX_EXT0    = 6'h24;
  localparam logic [5:0] IDX_EXT1    = 6'h25;
  localparam logic [5:0] IDX_TEMP    = 6'h26;
  localparam logic [5:0] IDX_DIAG    = 6'h27;
  localparam logic [5:0] IDX_OFFSET  = 6'h28;
  localparam logic [5:0] IDX_BYP     = 6'h2E;
  localparam logic [5:0] IDX_THR0    = 6'h30;
  localparam logic [5:0] IDX_THR1    = 6'h31;
  localparam logic [5:0] IDX_THRT    = 6'h32;
  localparam logic [5:0] IDX_SD4_THR = 6'h33;
  localparam logic [5:0] IDX_STATUS  = 6'h34;
  localparam logic [5:0] IDX_MASK    = 6'h35;
  localparam logic [5:0] IDX_ACT     = 6'h36;
  localparam logic [5:0] IDX_SPECIAL = 6'h37;

  // field positions
  localparam int unsigned CTRL_RATE_LSB = 0;
  localparam int unsigned CTRL_SPAN_BIT = 2;
  localparam int unsigned CTRL_RUN_BIT  = 3;
  localparam int unsigned BYP_OFS_BIT   = 12;
  localparam int unsigned BYP_RES_BIT   = 13;
  localparam int unsigned SPC_POL_BIT   = 0;
  localparam int unsigned SPC_DIS_BIT   = 1;

  // reset values
  localparam logic [15:0] THR_RST     = 16'hFF00;
  localparam logic [23:0] SD4_THR_RST = 24'hFFF_000;
  localparam logic [13:0] MASK_RST    = 14'h0000;

  // sequencer slots
  localparam logic [3:0] SLOT_OFFSET = 4'h0;
  localparam logic [3:0] SLOT_EXT0   = 4'h1;
  localparam logic [3:0] SLOT_EXT1   = 4'h2;
  localparam logic [3:0] SLOT_TEMP   = 4'h3;
  localparam logic [3:0] SLOT_SD0    = 4'h4;
  localparam logic [3:0] SLOT_SD4    = 4'h8;

  localparam logic [11:0] OFFSET_REF = 12'h7FF;
  localparam logic [11:0] CODE_MIN   = 12'h000;
  localparam logic [11:0] CODE_MAX   = 12'hFFF;
  localparam logic [3:0]  THR_LO_LSB = 4'h0;
  localparam logic [3:0]  THR_HI_LSB = 4'hF;

  // fixed windows for the reference, supply, core supply and flat-drift nodes
  localparam logic [47:0] SD_LO_TAB = 48'h690_9C0_310_6D0;
  localparam logic [47:0] SD_HI_TAB = 48'h8CF_D3F_D3F_92F;

  // fault response codes, low to high precedence
  localparam logic [1:0] ACT_NONE  = 2'h0;
  localparam logic [1:0] ACT_CLEAR = 2'h1;
  localparam logic [1:0] ACT_LEVEL = 2'h2;
  localparam logic [1:0] ACT_HIZ   = 2'h3;

  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

endpackage

// >>> design/fault_flag.sv
// one sticky status bit: hardware set wins over a clear in the same cycle
`timescale 1ns/1ps
`default_nettype none
module fault_flag (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output var  logic flag_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_o <= 1'b0;
    end else if (set_i) begin
      flag_o <= 1'b1;
    end else if (clr_i) begin
      flag_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> design/result_path.sv
// offset correction and bypass substitution of one conversion
`timescale 1ns/1ps
`default_nettype none
module result_path
  import diag_adc_pkg::*;
(
  input  wire logic [11:0] conv_i,
  input  wire logic [11:0] subst_i,
  input  wire logic [11:0] offset_i,
  input  wire logic        offset_sub_en_i,
  input  wire logic        result_sub_en_i,
  input  wire logic        offset_slot_i,
  output var  logic [11:0] value_o
);
  logic signed [13:0] diff;
  logic        [11:0] ofs;

  always_comb begin
    ofs  = offset_sub_en_i ? subst_i : offset_i;
    diff = $signed({2'b00, conv_i}) - $signed({ofs[11], ofs[11], ofs});
    if (result_sub_en_i) begin
      value_o = subst_i;
    end else if (offset_slot_i) begin
      // the stored value is the negative of the measured offset
      value_o = OFFSET_REF - conv_i;
    end else if (diff < 0) begin
      value_o = CODE_MIN;
    end else if (diff > $signed({2'b00, CODE_MAX})) begin
      value_o = CODE_MAX;
    end else begin
      value_o = diff[11:0];
    end
  end
endmodule
`default_nettype wire

// >>> tb/adc_model.sv
// converter model: answers each start with a fixed code per slot
`timescale 1ns/1ps
`default_nettype none
module adc_model (
  input  wire logic        clk_i,
  input  wire logic        start_i,
  input  wire logic [3:0]  slot_i,
  output var  logic        done_o,
  output var  logic [11:0] data_o
);
  // slot zero reads 7fd, so the stored offset becomes 2
  logic [11:0] tab_q [0:8] = '{12'h7FD, 12'h123, 12'hABC, 12'h800, 12'h800,
                               12'h800, 12'hA00, 12'h800, 12'h800};
  logic [3:0]  slot_q = 4'h0;
  int          wait_q = 0;
  initial begin
    done_o = 1'b0;
    data_o = 12'h5A5;
  end
  // odd slots answer promptly, even ones late; data toggles when not valid
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    data_o <= ~data_o;
    if (start_i === 1'b1) begin
      slot_q <= slot_i;
      wait_q <= slot_i[0] ? 1 : 6;
    end else if (wait_q == 1) begin
      done_o <= 1'b1;
      data_o <= tab_q[slot_q];
      wait_q <= 0;
    end else if (wait_q > 1) begin
      wait_q <= wait_q - 1;
    end
  end
endmodule
`default_nettype wire

// >>> tb/diag_adc_alarm_monitor_bench.sv
// self-checking bench for the diagnostic converter and alarm block
`timescale 1ns/1ps
`default_nettype none
module diag_adc_alarm_monitor_bench;
  logic        CLK_I, RST_I, POR_I, AVS_READ_I, AVS_WRITE_I, EXT_SENSE_IN1_I, HIGH_SUPPLY_I;
  logic        CRC_FAULT_I, WATCHDOG_FAULT_I, REF_FAULT_I, OVERHEAT_FAULT_I, UNDERTEMP_FAULT_I;
  logic        MISC_EVENT_I, AVS_WAITREQUEST_O, ADC_START_O, ADC_SPAN_DOUBLE_O, ADC_DONE_I;
  logic        ALARM_O, DAC_ALARM_HIGH_O, DAC_RELOAD_O, span1;
  logic [7:0]  AVS_ADDRESS_I;
  logic [31:0] AVS_WRITEDATA_I, AVS_READDATA_O, rd;
  logic [1:0]  AVS_RESPONSE_O, DAC_RESP_O, rs;
  logic [3:0]  ADC_SLOT_O;
  logic [11:0] ADC_DATA_I;
  int          miscompares, total_checks, reloads;

  // short periods keep a full slot sweep to a few hundred cycles
  diag_adc_alarm_monitor #(.PER_640_CYC(20), .PER_1280_CYC(30), .PER_2560_CYC(40),
    .PER_3840_CYC(50)) DUT (.CLK_I(CLK_I), .RST_I(RST_I), .POR_I(POR_I),
    .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
    .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(4'hF),
    .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
    .AVS_RESPONSE_O(AVS_RESPONSE_O), .EXT_SENSE_IN1_I(EXT_SENSE_IN1_I),
    .HIGH_SUPPLY_I(HIGH_SUPPLY_I), .ADC_START_O(ADC_START_O), .ADC_SLOT_O(ADC_SLOT_O),
    .ADC_SPAN_DOUBLE_O(ADC_SPAN_DOUBLE_O), .ADC_DONE_I(ADC_DONE_I), .ADC_DATA_I(ADC_DATA_I),
    .CRC_FAULT_I(CRC_FAULT_I), .WATCHDOG_FAULT_I(WATCHDOG_FAULT_I), .REF_FAULT_I(REF_FAULT_I),
    .OVERHEAT_FAULT_I(OVERHEAT_FAULT_I), .UNDERTEMP_FAULT_I(UNDERTEMP_FAULT_I),
    .MISC_EVENT_I(MISC_EVENT_I), .ALARM_O(ALARM_O), .DAC_RESP_O(DAC_RESP_O),
    .DAC_ALARM_HIGH_O(DAC_ALARM_HIGH_O), .DAC_RELOAD_O(DAC_RELOAD_O));
  adc_model ADC (.clk_i(CLK_I), .start_i(ADC_START_O), .slot_i(ADC_SLOT_O),
    .done_o(ADC_DONE_I), .data_o(ADC_DATA_I));

  initial begin
    CLK_I = 1'b0;
    forever #25 CLK_I = ~CLK_I;
  end
  always @(posedge CLK_I) begin
    if (DAC_RELOAD_O === 1'b1) reloads <= reloads + 1;
    if (ADC_START_O === 1'b1 && ADC_SLOT_O === 4'h1) span1 <= ADC_SPAN_DOUBLE_O;
  end
  ////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK_I);
    AVS_ADDRESS_I <= a;
    AVS_WRITEDATA_I <= d;
    AVS_WRITE_I <= wr;
    AVS_READ_I <= !wr;
    for (n = 0; n < 20; n++) begin
      @(posedge CLK_I);
      if (AVS_WAITREQUEST_O === 1'b0) break;
    end
    rd = AVS_READDATA_O;
    rs = AVS_RESPONSE_O;
    AVS_READ_I <= 1'b0;
    AVS_WRITE_I <= 1'b0;
    if (n == 20) begin
      miscompares++;
      finish_test();
    end
  endtask
  task automatic poll(input logic [7:0] a, input logic [31:0] e);
    int k;
    for (k = 0; k < 200; k++) begin
      bus(0, a, 32'h0);
      if (rd === e) break;
    end
    chk(rd, e);
  endtask
  task automatic wresp(input logic [1:0] e);
    int k;
    for (k = 0; k < 10 && DAC_RESP_O !== e; k++) @(posedge CLK_I);
    chk({30'h0, DAC_RESP_O}, {30'h0, e});
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_bus();
    bus(1, 8'hB8, 32'h0);
    bus(0, 8'hB8, 32'h0);
    chk(rd, 32'h0);
    bus(0, 8'hFC, 32'h0);
    chk({30'h0, rs}, 32'h2);
    bus(1, 8'h90, 32'h0000_0ABC);
    $display("bus test done");
  endtask
  task automatic t_conv();
    bus(1, 8'h80, 32'h0000_0008);
    poll(8'h90, 32'h0000_0121);
    poll(8'h94, 32'h0000_0ABA);
    poll(8'h98, 32'h0000_07FE);
    poll(8'h9C, 32'h0000_07FE);
    chk({31'h0, span1}, 32'h1);
    $display("conversion test done");
  endtask
  task automatic t_alarm();
    int k;
    bus(1, 8'hD4, 32'h1);
    bus(1, 8'hC0, 32'h0000_FF20);
    poll(8'hD0, 32'h1);
    chk({31'h0, ALARM_O}, 32'h0);
    bus(1, 8'hD4, 32'h0);
    for (k = 0; k < 900 && ALARM_O !== 1'b1; k++) @(posedge CLK_I);
    chk({31'h0, ALARM_O}, 32'h1);
    HIGH_SUPPLY_I <= 1'b0;
    bus(1, 8'hC0, 32'h0000_FF00);
    // the sense 0 condition only clears on its next in-window conversion
    for (k = 0; k < 900 && !(ADC_START_O === 1'b1 && ADC_SLOT_O === 4'h1); k++) @(posedge CLK_I);
    chk({28'h0, ADC_SLOT_O}, 32'h1);
    chk({31'h0, ADC_SPAN_DOUBLE_O}, 32'h0);
    HIGH_SUPPLY_I <= 1'b1;
    poll(8'hD0, 32'h0);
    $display("alarm test done");
  endtask
  task automatic t_act();
    bus(1, 8'hD8, 32'h03FF_FFFF);
    MISC_EVENT_I <= 1'b1;
    repeat (4) @(posedge CLK_I);
    chk({30'h0, DAC_RESP_O}, 32'h0);
    chk({31'h0, ALARM_O}, 32'h1);
    MISC_EVENT_I <= 1'b0;
    bus(1, 8'hD8, 32'h000D_0000);
    bus(1, 8'hDC, 32'h1);
    CRC_FAULT_I <= 1'b1;
    WATCHDOG_FAULT_I <= 1'b1;
    wresp(2'h3);
    WATCHDOG_FAULT_I <= 1'b0;
    wresp(2'h1);
    bus(1, 8'hD8, 32'h0002_0000);
    wresp(2'h2);
    chk({31'h0, DAC_ALARM_HIGH_O}, 32'h1);
    CRC_FAULT_I <= 1'b0;
    wresp(2'h0);
    repeat (3) @(posedge CLK_I);
    chk(reloads, 32'h1);
    bus(0, 8'hD0, 32'h0);
    $display("action test done");
  endtask
  task automatic t_byp();
    bus(1, 8'hB8, 32'h0000_1010);
    poll(8'h90, 32'h0000_0113);
    bus(1, 8'hB8, 32'h0000_17FF);
    poll(8'h90, 32'h0000_0000);
    bus(1, 8'hB8, 32'h0000_2055);
    poll(8'h94, 32'h0000_0055);
    bus(1, 8'hB8, 32'h0);
    $display("bypass test done");
  endtask
  task automatic t_rst();
    bus(1, 8'hDC, 32'h3);
    RST_I <= 1'b1;
    repeat (2) @(posedge CLK_I);
    RST_I <= 1'b0;
    bus(0, 8'hDC, 32'h0);
    chk(rd, 32'h3);
    POR_I <= 1'b1;
    repeat (2) @(posedge CLK_I);
    POR_I <= 1'b0;
    bus(0, 8'hDC, 32'h0);
    chk(rd, 32'h0);
    $display("reset test done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {RST_I, POR_I, HIGH_SUPPLY_I, AVS_READ_I, AVS_WRITE_I, EXT_SENSE_IN1_I} = 6'b111000;
    {CRC_FAULT_I, WATCHDOG_FAULT_I, REF_FAULT_I, OVERHEAT_FAULT_I} = 4'h0;
    {UNDERTEMP_FAULT_I, MISC_EVENT_I, span1} = 3'b000;
    AVS_ADDRESS_I = 8'h00;
    AVS_WRITEDATA_I = 32'h0;
    miscompares = 0;
    total_checks = 0;
    reloads = 0;
    repeat (8) @(posedge CLK_I);
    RST_I <= 1'b0;
    POR_I <= 1'b0;
    t_bus();
    t_conv();
    t_alarm();
    t_act();
    t_byp();
    t_rst();
    finish_test();
  end
endmodule
`default_nettype wire
